//--- xor_swap_direction_load_exec.sv
`timescale 1ns/1ps
module xor_swap_direction_load_exec #(
  parameter int PHASES = xst_pkg::PHASES
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  // Program fetch
  input  wire logic                 i_word_valid,
  input  wire logic [13:0]          i_word,
  output logic                      o_word_ready,
  // File register read port (operand)
  output logic [6:0]                o_file_raddr,
  input  wire logic [7:0]           i_file_rdata,
  // File register write port (result)
  output xst_pkg::xst_fwr_t         o_file_wr,
  // Status zero flag
  output logic                      o_zero_we,
  output logic                      o_zero,
  // Working register and direction registers
  output logic [7:0]                o_w,
  output logic [7:0]                o_dir [xst_pkg::DIR_NUM],
  // Phase and cycle end
  output logic [1:0]                o_phase,
  output logic                      o_cycle_done
);

  ////////////////////////////////////////////////////////////////////////
  // Phase sequencer
  //
  // The sequencer runs only while an instruction is in flight. A new word
  // is taken either from idle or in the Q4 phase of the previous one, so
  // back-to-back instructions keep one instruction per four clocks.
  // Trade-off: no overlap of fetch and execute beyond that single slot.

  // Q1 decode, Q2 operand read, Q3 process, Q4 write
  typedef enum logic [1:0] {
    XST_Q1,
    XST_Q2,
    XST_Q3,
    XST_Q4
  } xst_phase_t;

  xst_phase_t ph_reg;                    // Current phase
  xst_phase_t ph_next;                   // Next phase
  logic       busy_reg;                  // An instruction is in flight

  // Word taken only in idle or at the end of a cycle
  assign o_word_ready = !busy_reg || (ph_reg == XST_Q4);
  wire logic take     = i_word_valid && o_word_ready;

  // Phase advance
  // Wraps Q4 back to Q1; the default only catches an unknown state
  always_comb begin
    case (ph_reg)
      XST_Q1:  ph_next = XST_Q2;
      XST_Q2:  ph_next = XST_Q3;
      XST_Q3:  ph_next = XST_Q4;
      XST_Q4:  ph_next = XST_Q1;
      default: ph_next = XST_Q1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode

  logic [13:0]       word_reg;           // Held instruction word
  xst_pkg::xst_dec_t dec;                // Fields of the held word

  // The held word stays put from take to the end of Q4, so every field
  // that the write-back needs is still valid in the last phase.

  xst_decode i_xst_decode (
    .i_word (word_reg),
    .o_dec  (dec)
  );

  ////////////////////////////////////////////////////////////////////////
  // Operand read and process
  //
  // Q2 latches the operand: the literal field for the literal form, a
  // direction register for addresses 05..07, the file read data otherwise.
  // Q3 latches the result, so the Q4 write data comes from a flop and
  // never depends on the read port during the write phase.

  logic [7:0] w_reg;                     // Working register
  logic [7:0] dir_reg [xst_pkg::DIR_NUM]; // Direction registers
  logic [7:0] opnd_reg;                  // Operand latched in Q2
  logic [7:0] res_reg;                   // Result latched in Q3

  // Direction register index from file address or selector
  function automatic logic [1:0] dir_idx(input logic [6:0] a);
    dir_idx = 2'(a - xst_pkg::DIR_ADDR_BASE);
  endfunction

  // Address hits a direction register alias
  wire logic addr_is_dir = (dec.addr >= xst_pkg::DIR_ADDR_BASE) &&
                           (dec.addr < xst_pkg::DIR_ADDR_BASE + 7'(xst_pkg::DIR_NUM));
  // Operand mux: direction registers served locally, else file port
  wire logic [7:0] file_val = addr_is_dir ? dir_reg[dir_idx(dec.addr)] : i_file_rdata;
  wire logic [7:0] opnd_sel = (dec.op == xst_pkg::XST_OP_XOR_LIT) ? dec.lit : file_val;

  // Process: XOR or swap
  // Direction load passes W through unchanged as its result
  wire logic [7:0] res_sel =
    (dec.op == xst_pkg::XST_OP_SWAP)     ? {opnd_reg[3:0], opnd_reg[7:4]} :
    (dec.op == xst_pkg::XST_OP_DIR_LOAD) ? w_reg :
                                           (w_reg ^ opnd_reg);

  assign o_file_raddr = dec.addr;

  ////////////////////////////////////////////////////////////////////////
  // Write-back steering
  //
  // At most one destination per instruction, none for a no-op word. Literal XOR always goes to W;
  // file XOR and swap follow the destination bit; the direction load only
  // touches the selected direction register.

  wire logic in_q4    = busy_reg && (ph_reg == XST_Q4);
  wire logic is_xorl  = (dec.op == xst_pkg::XST_OP_XOR_LIT);
  wire logic is_steer = (dec.op == xst_pkg::XST_OP_XOR_FILE) || (dec.op == xst_pkg::XST_OP_SWAP);
  wire logic is_dir   = (dec.op == xst_pkg::XST_OP_DIR_LOAD);
  wire logic is_xor   = is_xorl || (dec.op == xst_pkg::XST_OP_XOR_FILE);

  // Destination 0 or literal form writes W
  wire logic w_we     = in_q4 && (is_xorl || (is_steer && !dec.dest));
  // Destination 1 writes back to the file
  wire logic f_we     = in_q4 && is_steer && dec.dest;
  // File write that lands on a direction alias is kept here
  wire logic f_dir_we = f_we && addr_is_dir;
  wire logic d_we     = in_q4 && is_dir;

  ////////////////////////////////////////////////////////////////////////
  // State registers

  // Sequencer, fetch latch and datapath stages
  // Synchronous reset only; operand and result latches are cleared
  // just to keep them out of unknown values, nothing reads them idle.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ph_reg   <= XST_Q1;
      busy_reg <= 1'b0;
      word_reg <= 14'h0000;
      opnd_reg <= 8'h00;
      res_reg  <= 8'h00;
    end else begin
      // A take restarts at Q1; otherwise the phase advances while busy and holds when idle
      if (take) begin
        word_reg <= i_word;
        busy_reg <= 1'b1;
        ph_reg   <= XST_Q1;
      end else if (busy_reg) begin
        ph_reg   <= ph_next;
        busy_reg <= (ph_reg != XST_Q4);
      end
      // Operand sampled at the end of Q2
      if (busy_reg && ph_reg == XST_Q2) begin
        opnd_reg <= opnd_sel;
      end
      // Result sampled at the end of Q3
      if (busy_reg && ph_reg == XST_Q3) begin
        res_reg  <= res_sel;
      end
    end
  end

  // Working register
  // Only the Q4 strobe writes W, so an unknown word leaves it alone
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      w_reg <= xst_pkg::W_RESET;
    end else if (w_we) begin
      w_reg <= res_reg;
    end
  end

  // Direction registers, one per port
  // Limitation: only three ports have direction registers; selector
  // values 0..4 of the direction load decode as a no-op.
  genvar gi;
  generate
    for (gi = 0; gi < xst_pkg::DIR_NUM; gi++) begin : g_dir
      wire logic sel_load = d_we && (dir_idx(7'(dec.dir_sel)) == 2'(gi));
      wire logic sel_file = f_dir_we && (dir_idx(dec.addr) == 2'(gi));
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          dir_reg[gi] <= xst_pkg::DIR_RESET;
        end else if (sel_load || sel_file) begin
          dir_reg[gi] <= res_reg;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  //
  // Write strobes are combinational from the phase and the held word and
  // last exactly the Q4 clock. Data on every port comes from flops.
  // The file write is masked on direction aliases: those bytes live here,
  // so the outer file never holds a stale copy of them.

  // Zero flag only for the XOR forms; swap and direction-load leave it
  assign o_zero_we     = in_q4 && is_xor;
  assign o_zero        = (res_reg == 8'h00);
  assign o_file_wr.we   = f_we && !addr_is_dir;
  assign o_file_wr.addr = dec.addr;
  assign o_file_wr.data = res_reg;
  assign o_w           = w_reg;
  assign o_dir         = dir_reg;
  assign o_phase       = ph_reg;
  assign o_cycle_done  = in_q4;

endmodule

//--- xor_swap_direction_load_exec_test.sv
`timescale 1ns/1ps
// Self-checking bench for the execution block
module xor_swap_direction_load_exec_test;
  // Expected outcome of one instruction
  typedef struct packed {
    logic [7:0]  w;
    logic [23:0] dir;
    logic        we;
    logic [7:0]  data;
    logic        zw;
    logic        z;
    logic [6:0]  a;
  } xst_exp_t;
  logic              i_clk = 1'b0;
  logic              i_rst_n = 1'b0;
  logic              i_word_valid = 1'b0;
  logic [13:0]       i_word = 14'h0000;
  logic [7:0]        i_file_rdata = 8'h00;
  logic              o_word_ready, o_zero_we, o_zero, o_cycle_done;
  logic [6:0]        o_file_raddr;
  xst_pkg::xst_fwr_t o_file_wr;
  logic [7:0]        o_w;
  logic [7:0]        o_dir [xst_pkg::DIR_NUM];
  logic [1:0]        o_phase;
  xst_exp_t          exp_q [$];
  logic [7:0]        w_m = 8'h00;       // Model of W
  logic [23:0]       d_m = 24'hffffff;  // Model of direction regs
  logic [13:0]       ops [3] = '{xst_pkg::XOR_LIT_CODE, xst_pkg::XOR_FILE_CODE, xst_pkg::SWAP_CODE};
  int                num_errors = 0;
  int                checks = 0;
  always #20 i_clk = ~i_clk;
  xor_swap_direction_load_exec i_xor_swap_direction_load_exec (.i_clk, .i_rst_n, .i_word_valid, .i_word, .o_word_ready,
    .o_file_raddr, .i_file_rdata, .o_file_wr, .o_zero_we, .o_zero, .o_w, .o_dir, .o_phase, .o_cycle_done);
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
    checks++;
    if (e !== s) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Offer a word, note its outcome, give the operand once taken
  task automatic exec(input logic [13:0] wd, input logic [7:0] rd);
    xst_exp_t e;
    logic [7:0] r;
    logic lt, xf, sw, rdy;
    int ix;
    ix = int'(wd[6:0]) - 5;
    if ((ix >= 0) && (ix < 3)) rd = d_m[ix*8 +: 8]; // Alias must read back the same value
    lt = (wd & xst_pkg::XOR_LIT_MASK) == xst_pkg::XOR_LIT_CODE;
    xf = (wd & xst_pkg::XOR_FILE_MASK) == xst_pkg::XOR_FILE_CODE;
    sw = (wd & xst_pkg::SWAP_MASK) == xst_pkg::SWAP_CODE;
    r = lt ? w_m ^ wd[7:0] : xf ? w_m ^ rd : {rd[3:0], rd[7:4]};
    e = '0;
    e.a = wd[6:0];
    e.zw = lt || xf;
    e.z = (r == 8'h00);
    if ((wd & xst_pkg::DIR_MASK) == xst_pkg::DIR_CODE && wd[2:0] >= 3'h5) begin
      d_m[(int'(wd[2:0]) - 5)*8 +: 8] = w_m;
    end else if (lt || ((xf || sw) && !wd[7])) begin
      w_m = r;
    end else if ((xf || sw) && ix >= 0 && ix < 3) begin
      d_m[ix*8 +: 8] = r;
    end else if (xf || sw) begin
      e.we = 1'b1;
      e.data = r;
    end
    e.w = w_m;
    e.dir = d_m;
    i_word_valid <= 1'b1;
    i_word <= wd;
    do begin
      @(negedge i_clk);
      rdy = o_word_ready;
      @(posedge i_clk);
    end while (rdy !== 1'b1);
    i_file_rdata <= rd;
    exp_q.push_back(e);
  endtask
  // Scoreboard on each cycle end
  initial begin
    xst_exp_t e;
    forever begin
      @(negedge i_clk);
      if (o_cycle_done === 1'b1) begin
        chk("queue", 24'h000001, 24'(exp_q.size() > 0));
        e = exp_q.pop_front();
        chk("phase", 24'(xst_pkg::PHASES - 1), o_phase);
        chk("raddr", e.a, o_file_raddr);
        chk("file_we", e.we, o_file_wr.we);
        if (e.we) chk("file_data", e.data, o_file_wr.data);
        if (e.we) chk("file_addr", e.a, o_file_wr.addr);
        chk("zero_we", e.zw, o_zero_we);
        if (e.zw) chk("zero", e.z, o_zero);
        @(negedge i_clk);
        chk("w", e.w, o_w);
        chk("dir", e.dir, {o_dir[2], o_dir[1], o_dir[0]});
      end
    end
  end
  // Watchdog, far beyond the expected 355 or so cycles
  initial begin
    repeat (3000) @(posedge i_clk);
    num_errors++;
    stop_test();
  end
  initial begin
    logic [31:0] k;
    void'($urandom(98));
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    chk("dir_reset", 24'hffffff, {o_dir[2], o_dir[1], o_dir[0]});
    chk("w_reset", 24'(xst_pkg::W_RESET), o_w);
    chk("ready_reset", 24'h000001, o_word_ready);
    exec(14'h3ab5, 8'h00);
    exec(14'h3aaf, 8'h00);
    exec(14'h3a1a, 8'h00);
    exec(14'h06ff, 8'haf);
    exec(14'h0610, 8'h5a);
    exec(14'h0e23, 8'ha5);
    exec(14'h0ea4, 8'h3c);
    for (int i = 0; i < 8; i++) begin
      exec(14'h3a00 | 14'(i * 17), 8'h00);
      exec(14'h0060 | 14'(i), 8'h00);
    end
    exec(14'h0685, 8'h00);
    exec(14'h0e86, 8'h00);
    exec(14'h3fff, 8'h00);
    i_word_valid <= 1'b0;
    repeat (6) @(posedge i_clk);
    for (int i = 0; i < 60; i++) begin
      k = $urandom;
      exec(ops[k[25:24] % 3] | {6'h00, k[7:0]}, k[15:8]);
    end
    i_word_valid <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk("pending", 24'h000000, 24'(exp_q.size()));
    stop_test();
  end
endmodule

//--- xst_decode.sv
`timescale 1ns/1ps
// Combinational instruction decoder
module xst_decode (
  // Instruction word
  input  wire logic [13:0]       i_word,
  // Decoded fields
  output xst_pkg::xst_dec_t      o_dec
);

  // Masked compare, used for every opcode class
  function automatic logic match(input logic [13:0] w, input logic [13:0] m, input logic [13:0] c);
    match = ((w & m) == c);
  endfunction

  // Class hits
  wire logic hit_lit  = match(i_word, xst_pkg::XOR_LIT_MASK, xst_pkg::XOR_LIT_CODE);
  wire logic hit_file = match(i_word, xst_pkg::XOR_FILE_MASK, xst_pkg::XOR_FILE_CODE);
  wire logic hit_swap = match(i_word, xst_pkg::SWAP_MASK, xst_pkg::SWAP_CODE);
  wire logic hit_dir  = match(i_word, xst_pkg::DIR_MASK, xst_pkg::DIR_CODE);
  // Only 5..7 are real direction targets; others decode as no-op
  wire logic dir_ok   = (i_word[2:0] >= xst_pkg::DIR_SEL_MIN) && (i_word[2:0] <= xst_pkg::DIR_SEL_MAX);

  // Operation select
  wire xst_pkg::xst_op_t op_sel =
    hit_lit              ? xst_pkg::XST_OP_XOR_LIT  :
    hit_file             ? xst_pkg::XST_OP_XOR_FILE :
    hit_swap             ? xst_pkg::XST_OP_SWAP     :
    (hit_dir && dir_ok)  ? xst_pkg::XST_OP_DIR_LOAD :
                           xst_pkg::XST_OP_NONE;

  assign o_dec.op      = op_sel;
  assign o_dec.lit     = i_word[7:0];
  assign o_dec.addr    = i_word[6:0];
  assign o_dec.dest    = i_word[xst_pkg::DEST_BIT];
  assign o_dec.dir_sel = i_word[2:0];

endmodule

//--- xst_exec_properties.sv
`timescale 1ns/1ps
// Port-level timing and datapath checks
module xst_props (
  // Clock and reset
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  // Fetch side
  input wire logic              i_word_valid,
  input wire logic [13:0]       i_word,
  input wire logic              o_word_ready,
  input wire logic [7:0]        i_file_rdata,
  // Results
  input wire xst_pkg::xst_fwr_t o_file_wr,
  input wire logic              o_zero_we,
  input wire logic              o_zero,
  input wire logic [7:0]        o_w,
  input wire logic [7:0]        o_dir [xst_pkg::DIR_NUM],
  input wire logic [1:0]        o_phase,
  input wire logic              o_cycle_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////
  logic [13:0] wq_reg; // Word in flight
  logic [7:0]  rd_reg; // Operand seen in Q2
  wire tk = i_word_valid && o_word_ready;
  wire xl = (wq_reg & xst_pkg::XOR_LIT_MASK) == xst_pkg::XOR_LIT_CODE;
  wire xf = (wq_reg & xst_pkg::XOR_FILE_MASK) == xst_pkg::XOR_FILE_CODE;
  wire sw = (wq_reg & xst_pkg::SWAP_MASK) == xst_pkg::SWAP_CODE;
  wire dl = (wq_reg & xst_pkg::DIR_MASK) == xst_pkg::DIR_CODE && wq_reg[2:0] >= 3'h5;
  // Word kept until the next take, so Q4 still sees its own word
  always_ff @(posedge i_clk) begin
    if (tk) wq_reg <= i_word;
    if (o_phase == 2'h1) rd_reg <= i_file_rdata;
  end
  property p_done; tk |-> ##4 o_cycle_done; endproperty
  a_done: assert property (p_done) else $error("cycle end late");
  property p_busy; tk |=> !o_word_ready [*3] ##1 o_word_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready wrong");
  property p_zwe; o_zero_we |-> o_cycle_done && (xl || xf); endproperty
  a_zwe: assert property (p_zwe) else $error("flag write wrong");
  property p_xl; o_cycle_done && xl |=> o_w == ($past(o_w) ^ $past(wq_reg[7:0])) && $past(o_zero) == (o_w == 8'h00);
  endproperty
  a_xl: assert property (p_xl) else $error("literal xor wrong");
  property p_fwe; o_file_wr.we |-> o_cycle_done && wq_reg[7] && (xf || sw) && o_file_wr.addr == wq_reg[6:0];
  endproperty
  a_fwe: assert property (p_fwe) else $error("file write wrong");
  property p_xfd; o_file_wr.we && xf |-> o_file_wr.data == (rd_reg ^ o_w) && o_zero == (o_file_wr.data == 8'h00);
  endproperty
  a_xfd: assert property (p_xfd) else $error("file xor wrong");
  property p_sw; o_cycle_done && sw && !wq_reg[7] |=> o_w == {$past(rd_reg[3:0]), $past(rd_reg[7:4])}; endproperty
  a_sw: assert property (p_sw) else $error("swap wrong");
  property p_dir; o_cycle_done && dl |=> o_dir[$past(wq_reg[2:0]) - 3'h5] == $past(o_w); endproperty
  a_dir: assert property (p_dir) else $error("direction load wrong");
  property p_keep; o_cycle_done && (xf || sw) && wq_reg[7] |=> $stable(o_w); endproperty
  a_keep: assert property (p_keep) else $error("W changed on file destination");
  cover property (o_cycle_done && sw && !wq_reg[7]);
  cover property (tk);
  cover property (o_file_wr.we);
  cover property (o_cycle_done && dl);
endmodule
bind xor_swap_direction_load_exec xst_props i_xst_props (.i_clk, .i_rst_n, .i_word_valid, .i_word, .o_word_ready,
  .i_file_rdata, .o_file_wr, .o_zero_we, .o_zero, .o_w, .o_dir, .o_phase, .o_cycle_done);

//--- xst_pkg.sv
package xst_pkg;

  // Instruction word and operand widths
  localparam int WORD_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;

  // Opcode patterns, compared under masks
  localparam logic [13:0] XOR_LIT_MASK  = 14'h3f00;
  localparam logic [13:0] XOR_LIT_CODE  = 14'h3a00;
  localparam logic [13:0] XOR_FILE_MASK = 14'h3f00;
  localparam logic [13:0] XOR_FILE_CODE = 14'h0600;
  localparam logic [13:0] SWAP_MASK     = 14'h3f00;
  localparam logic [13:0] SWAP_CODE     = 14'h0e00;
  localparam logic [13:0] DIR_MASK      = 14'h3ff8;
  localparam logic [13:0] DIR_CODE      = 14'h0060;

  // Field positions inside the instruction word
  localparam int DEST_BIT  = 7;
  localparam int DIR_SEL_W = 3;

  // Direction-load target range
  localparam logic [2:0] DIR_SEL_MIN = 3'h5;
  localparam logic [2:0] DIR_SEL_MAX = 3'h7;
  localparam int         DIR_NUM     = 3;

  // File addresses of the direction registers (bank 1 aliases of ports)
  localparam logic [6:0] DIR_ADDR_BASE = 7'h05;

  // Reset values
  localparam logic [7:0] W_RESET   = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hff;

  // Phase count per instruction cycle
  localparam int PHASES = 4;

  // Decoded operation kind
  typedef enum logic [2:0] {
    XST_OP_NONE,
    XST_OP_XOR_LIT,
    XST_OP_XOR_FILE,
    XST_OP_SWAP,
    XST_OP_DIR_LOAD
  } xst_op_t;

  // Decoded instruction fields
  typedef struct packed {
    xst_op_t     op;
    logic [7:0]  lit;
    logic [6:0]  addr;
    logic        dest;
    logic [2:0]  dir_sel;
  } xst_dec_t;

  // Write-back bundle toward the file register
  typedef struct packed {
    logic        we;
    logic [6:0]  addr;
    logic [7:0]  data;
  } xst_fwr_t;

endpackage
